// ---- ptc_regs.vh ----
// constants for the packet timestamp clock
`ifndef PTC_REGS_VH
`define PTC_REGS_VH

// clock and time base
`define CLK_PERIOD_NS    100
`define NS_PER_SEC       1000000000
`define FINE_FRAC_BITS   48
`define FRAC_INC_CALC    ((64'h1 << `FINE_FRAC_BITS) * `CLK_PERIOD_NS / `NS_PER_SEC)

// timestamp layout
`define STAMP_WIDTH      64
`define SEC_MSB          63
`define SEC_LSB          32
`define FRAC_MSB         31
`define ACTIVE_FRAC_BITS 26
`define ACTIVE_FRAC_LSB  6

// discipline and health
`define THRESH_DEFAULT_NS 32'h0000_0254
`define LOSS_SECONDS      4'ha
`define HOST_MAX_DIFF     32'h0000_0001
`define TRIM_WIDTH        16

// sync input and output selections
`define IN_SEL_RS422     1'b0
`define IN_SEL_INTERNAL  1'b1
`define OUT_SEL_NONE     2'h0
`define OUT_SEL_REPEAT   2'h1
`define OUT_SEL_LOOP     2'h2
`define OUT_SEL_MASTER   2'h3

`endif

// ---- pulse_edge_sync.v ----
// three-stage pin synchroniser with rising edge detection
`default_nettype none

module pulse_edge_sync
(
    input  wire clk,
    input  wire rst_sync_n,
    input  wire pin,
    output reg  level,
    output reg  rise
);

    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
            rise   <= 1'b0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            rise   <= 1'b0;
            // a change counts once the second and third stages agree
            if (stage2 == stage3)
            begin
                level <= stage3;
                rise  <= stage3 & ~level;
            end
        end
    end

endmodule

`default_nettype wire

// ---- packet_timestamp_clock.v ----
// time-of-day clock that stamps packets and follows a pulse-per-second reference
`include "ptc_regs.vh"
`default_nettype none

// How it works
// - every packet arrival captures the running time into the stamp register
// - stamp is one 64-bit fixed-point seconds count since 1970, little-endian bytes
// - upper 32 bits hold whole seconds, lower 32 bits the binary fraction
// - counter drives only the top 26 fraction bits, about 14.9 ns per tick
// - fraction bits below the 26 active bits always read zero
// - host loads an initial time, then the crystal advances the clock
// - pulse-per-second reference input from the RS-422 receiver disciplines the clock
// - with sync on, seconds compared to host once per second; over 1 reloads
// - a synchronisation signal is driven out of the sync connector
// - loss of sync after ten consecutive seconds of phase error above threshold
// - threshold defaults to 596 ns and software may change it
// - a selectable output mode repeats the received RS-422 reference pulse
module packet_timestamp_clock
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire        packet_arrive,
    output reg  [63:0] packet_stamp,
    output reg         packet_stamp_valid,
    input  wire        host_load,
    input  wire [31:0] host_seconds,
    input  wire [31:0] host_fraction,
    input  wire        sync_enable,
    input  wire        input_select,
    input  wire [1:0]  output_select,
    input  wire        threshold_load,
    input  wire [31:0] threshold_value,
    input  wire        rs422_pps_in,
    input  wire        internal_pps_in,
    output reg         sync_out,
    output reg         synchronised,
    output reg         sync_lost,
    output reg  [31:0] phase_error_ns,
    output reg         phase_error_late,
    output reg  [15:0] resync_count,
    output reg  [31:0] threshold_ns,
    output reg  [63:0] current_time
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release and reference inputs

    reg rst_meta_n;
    reg rst_sync_n;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    wire rs422_level;
    wire rs422_rise;
    wire internal_level;
    wire internal_rise;

    pulse_edge_sync rs422_sync
    (
        .clk        (clk),
        .rst_sync_n (rst_sync_n),
        .pin        (rs422_pps_in),
        .level      (rs422_level),
        .rise       (rs422_rise)
    );

    pulse_edge_sync internal_sync
    (
        .clk        (clk),
        .rst_sync_n (rst_sync_n),
        .pin        (internal_pps_in),
        .level      (internal_level),
        .rise       (internal_rise)
    );

    wire ref_rise  = (input_select == `IN_SEL_RS422) ? rs422_rise : internal_rise;
    wire ref_level = (input_select == `IN_SEL_RS422) ? rs422_level : internal_level;

    ////////////////////////////////////////////////////////////////////////////
    // time base: whole seconds plus a fine fraction accumulator

    localparam [63:0] inc_full = `FRAC_INC_CALC;
    wire [47:0] frac_inc_nominal = inc_full[47:0];

    reg  [31:0]             seconds;
    reg  [47:0]             fine_frac;
    reg  signed [15:0]      trim;
    reg                     locked;
    reg  [3:0]              bad_seconds;

    wire [47:0] trim_ext = {{32{trim[15]}}, trim};
    wire [48:0] frac_sum = {1'b0, fine_frac} + {1'b0, frac_inc_nominal + trim_ext};
    wire        second_roll = frac_sum[48];

    // only the top 26 fraction bits are active, the rest stay zero
    wire [25:0] active_frac = fine_frac[47:22];
    wire [63:0] time_now = {seconds, active_frac, 6'h00};

    // phase error: signed offset of the fraction from the nearest rollover
    wire        err_late = active_frac[25];
    wire [25:0] err_ticks = err_late ? (26'h000_0000 - active_frac) : active_frac;
    wire [55:0] err_product = {30'h0000_0000, err_ticks} * 56'h00_0000_3b9a_ca00;
    wire [31:0] err_ns = {2'h0, err_product[55:26]};

    wire [31:0] host_diff = (seconds > host_seconds) ? (seconds - host_seconds)
                                                     : (host_seconds - seconds);
    wire        host_mismatch = sync_enable && second_roll
                                && (host_diff > `HOST_MAX_DIFF);

    ////////////////////////////////////////////////////////////////////////////
    // clock advance, loading and discipline

    always @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            seconds      <= 32'h0000_0000;
            fine_frac    <= 48'h0000_0000_0000;
            trim         <= 16'sh0000;
            locked       <= 1'b0;
            bad_seconds  <= 4'h0;
            sync_lost    <= 1'b0;
            resync_count <= 16'h0000;
        end
        else if (host_load || host_mismatch)
        begin
            // host time restarts the clock and the discipline loop
            seconds     <= host_seconds;
            fine_frac   <= {host_fraction[31:6], 22'h00_0000};
            locked      <= 1'b0;
            bad_seconds <= 4'h0;
            sync_lost   <= 1'b0;
            trim        <= 16'sh0000;
            if (host_mismatch)
                resync_count <= resync_count + 16'h0001;
        end
        else if (sync_enable && ref_rise && !locked)
        begin
            // first edge after a restart snaps to the nearest whole second
            seconds   <= err_late ? seconds + 32'h0000_0001 : seconds;
            fine_frac <= 48'h0000_0000_0000;
            locked    <= 1'b1;
        end
        else
        begin
            fine_frac <= frac_sum[47:0];
            if (second_roll)
                seconds <= seconds + 32'h0000_0001;
            if (sync_enable && ref_rise)
            begin
                // slow frequency trim towards zero phase error
                if (err_late && trim != 16'sh7fff)
                    trim <= trim + 16'sh0001;
                else if (!err_late && err_ticks != 26'h000_0000 && trim != 16'sh8000)
                    trim <= trim - 16'sh0001;
                if (err_ns > threshold_ns)
                begin
                    if (bad_seconds != `LOSS_SECONDS)
                        bad_seconds <= bad_seconds + 4'h1;
                    if (bad_seconds == `LOSS_SECONDS - 4'h1)
                        sync_lost <= 1'b1;
                end
                else
                begin
                    bad_seconds <= 4'h0;
                    sync_lost   <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // threshold, status and packet stamps

    always @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            threshold_ns       <= `THRESH_DEFAULT_NS;
            phase_error_ns     <= 32'h0000_0000;
            phase_error_late   <= 1'b0;
            synchronised       <= 1'b0;
            packet_stamp       <= 64'h0000_0000_0000_0000;
            packet_stamp_valid <= 1'b0;
            current_time       <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            if (threshold_load)
                threshold_ns <= threshold_value;
            if (sync_enable && ref_rise && locked)
            begin
                phase_error_ns   <= err_ns;
                phase_error_late <= err_late;
            end
            synchronised       <= sync_enable && locked && !sync_lost;
            current_time       <= time_now;
            packet_stamp_valid <= packet_arrive;
            if (packet_arrive)
                packet_stamp <= time_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync connector output

    reg master_pulse;

    always @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            master_pulse <= 1'b0;
            sync_out     <= 1'b0;
        end
        else
        begin
            // master mode: high for the first half of every card second
            master_pulse <= ~active_frac[25];
            if (output_select == `OUT_SEL_REPEAT)
                sync_out <= rs422_level;
            else if (output_select == `OUT_SEL_LOOP)
                sync_out <= ref_level;
            else if (output_select == `OUT_SEL_MASTER)
                sync_out <= master_pulse;
            else
                sync_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- ptc_chk.sv ----
// port assertions for the packet timestamp clock
`default_nettype none
module ptc_chk
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        packet_arrive,
    input wire logic [63:0] packet_stamp,
    input wire logic        packet_stamp_valid,
    input wire logic        host_load,
    input wire logic [31:0] host_seconds,
    input wire logic [1:0]  output_select,
    input wire logic        threshold_load,
    input wire logic [31:0] threshold_value,
    input wire logic        sync_out,
    input wire logic        synchronised,
    input wire logic        sync_lost,
    input wire logic [15:0] resync_count,
    input wire logic [31:0] threshold_ns,
    input wire logic [63:0] current_time
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    stamp_valid_a: assert property (packet_arrive |=> packet_stamp_valid)
        else $error("no stamp after packet arrival");
    valid_cause_a: assert property (packet_stamp_valid |-> $past(packet_arrive))
        else $error("stamp without packet arrival");
    stamp_pad_a: assert property (packet_stamp_valid |-> packet_stamp[5:0] == 6'h00)
        else $error("inactive stamp bits not zero");
    time_pad_a: assert property (current_time[5:0] == 6'h00)
        else $error("inactive time bits not zero");
    host_load_a: assert property (host_load ##1 !host_load |=>
        current_time[63:32] == $past(host_seconds, 2))
        else $error("host seconds not loaded");
    thresh_load_a: assert property (threshold_load |=>
        threshold_ns == $past(threshold_value))
        else $error("threshold not written");
    sync_none_a: assert property (output_select == 2'h0 |=> !sync_out)
        else $error("sync output active with no source");
    loss_flag_a: assert property ($rose(sync_lost) |=> !synchronised)
        else $error("synchronised while lost");
    resync_step_a: assert property ($changed(resync_count) |->
        resync_count == $past(resync_count) + 16'h0001)
        else $error("resync count jumped");
    cover property (packet_arrive ##1 packet_arrive);
    cover property ($rose(sync_lost));
    cover property ($rose(sync_out));
endmodule
bind packet_timestamp_clock ptc_chk u_chk (.clk, .rst_n, .packet_arrive, .packet_stamp,
    .packet_stamp_valid, .host_load, .host_seconds, .output_select, .threshold_load,
    .threshold_value, .sync_out, .synchronised, .sync_lost, .resync_count, .threshold_ns,
    .current_time);
`default_nettype wire

// ---- pps_ref.sv ----
// pulse-per-second reference source for the bench
`default_nettype none
module pps_ref
(
    input  wire logic clk,
    output var  logic rs422_pps_in,
    output var  logic internal_pps_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rs422_pps_in = 1'b0;
    initial internal_pps_in = 1'b0;
    // active-high pulse on the chosen source, idle low between pulses
    task pulse(input logic sel, input int hi);
        @(posedge clk);
        #1;
        if (sel) internal_pps_in = 1'b1;
        else rs422_pps_in = 1'b1;
        repeat (hi) @(posedge clk);
        #1;
        internal_pps_in = 1'b0;
        rs422_pps_in = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- packet_timestamp_clock_tb.sv ----
// self-checking bench for the packet timestamp clock
`include "ptc_regs.vh"
`default_nettype none
module packet_timestamp_clock_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_n = 0, packet_arrive = 0, host_load = 0, sync_enable = 0;
    logic        input_select = 0, threshold_load = 0;
    logic [1:0]  output_select = 0;
    logic [31:0] host_seconds = 0, host_fraction = 0, threshold_value = 0;
    logic        rs422_pps_in, internal_pps_in, packet_stamp_valid, sync_out;
    logic        synchronised, sync_lost, phase_error_late;
    logic [63:0] packet_stamp, current_time, s1, d;
    logic [31:0] phase_error_ns, threshold_ns;
    logic [15:0] resync_count;
    int          errors = 0, samples_checked = 0, i;
    always #50 clk = ~clk;
    packet_timestamp_clock dut (.clk, .rst_n, .packet_arrive, .packet_stamp,
        .packet_stamp_valid, .host_load, .host_seconds, .host_fraction, .sync_enable,
        .input_select, .output_select, .threshold_load, .threshold_value, .rs422_pps_in,
        .internal_pps_in, .sync_out, .synchronised, .sync_lost, .phase_error_ns,
        .phase_error_late, .resync_count, .threshold_ns, .current_time);
    pps_ref ref_src (.clk, .rs422_pps_in, .internal_pps_in);
    ////////////////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task test_done;
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function logic pick(input int w);
        return (w == 0) ? sync_out : sync_lost;
    endfunction
    task automatic wait_sig(input string name, input int w, input logic v, input int n);
        int k;
        for (k = 0; k < n && pick(w) !== v; k++) tick(1);
        check(name, pick(w), v);
        if (pick(w) !== v) test_done();
    endtask
    task load(input logic [31:0] s, input logic [31:0] f);
        host_seconds = s;
        host_fraction = f;
        host_load = 1;
        tick(1);
        host_load = 0;
        tick(1);
    endtask
    task set_threshold(input logic [31:0] v);
        threshold_value = v;
        threshold_load = 1;
        tick(1);
        threshold_load = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(12);
        rst_n = 1;
        tick(3);
        check("threshold", threshold_ns, `THRESH_DEFAULT_NS);
        check("resyncs", resync_count, 16'h0000);
        load(32'h0000_0064, 32'h1234_5678);
        check("loaded", current_time, 64'h0000_0064_1234_5640);
        packet_arrive = 1;
        tick(1);
        check("valid1", packet_stamp_valid, 1'b1);
        check("stamp_sec", packet_stamp[63:32], 32'h0000_0064);
        check("stamp_pad", packet_stamp[5:0], 6'h00);
        s1 = packet_stamp;
        tick(1);
        packet_arrive = 0;
        check("valid2", packet_stamp_valid, 1'b1);
        d = packet_stamp - s1;
        check("stamp_step", d == 64'h180 || d == 64'h1c0, 1'b1);
        tick(1);
        check("valid3", packet_stamp_valid, 1'b0);
        set_threshold(32'h0000_03e8);
        check("thresh_set", threshold_ns, 32'h0000_03e8);
        output_select = `OUT_SEL_REPEAT;
        fork
            ref_src.pulse(`IN_SEL_RS422, 20);
            wait_sig("repeat_hi", 0, 1'b1, 10);
        join
        wait_sig("repeat_lo", 0, 1'b0, 10);
        output_select = `OUT_SEL_LOOP;
        input_select = `IN_SEL_INTERNAL;
        fork
            ref_src.pulse(`IN_SEL_INTERNAL, 20);
            wait_sig("loop_hi", 0, 1'b1, 10);
        join
        // card fraction is well below half a second here, so the master pulse is high
        output_select = `OUT_SEL_MASTER;
        tick(3);
        check("master", sync_out, 1'b1);
        output_select = `OUT_SEL_NONE;
        tick(2);
        check("out_none", sync_out, 1'b0);
        input_select = `IN_SEL_RS422;
        load(32'h0000_0100, 32'h0000_0000);
        sync_enable = 1;
        for (i = 0; i < 10; i++)
        begin
            ref_src.pulse(`IN_SEL_RS422, 5);
            tick(300);
        end
        check("not_lost", sync_lost, 1'b0);
        check("synced", synchronised, 1'b1);
        check("late", phase_error_late, 1'b0);
        // the fraction runs on from the lock edge: 2753 clocks of 100 ns at the last edge
        check("err", phase_error_ns > 32'h0004_3300
            && phase_error_ns < 32'h0004_33c8, 1'b1);
        ref_src.pulse(`IN_SEL_RS422, 5);
        wait_sig("lost", 1, 1'b1, 10);
        tick(2);
        check("unsynced", synchronised, 1'b0);
        set_threshold(32'hffff_ffff);
        ref_src.pulse(`IN_SEL_RS422, 5);
        wait_sig("regained", 1, 1'b0, 10);
        load(32'h0000_00c8, 32'hffff_0000);
        host_seconds = 32'h0000_00cd;
        host_fraction = 32'h0000_0000;
        for (i = 0; i < 400 && resync_count !== 16'h0001; i++) tick(1);
        check("resync", resync_count, 16'h0001);
        if (i == 400) test_done();
        tick(2);
        check("reload_sec", current_time[63:32], 32'h0000_00cd);
        test_done();
    end
    initial
    begin
        #9000000;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
